// ===== rtl/clock_ctrl_params.svh
// clock control constants: offsets, fields, resets, fuse codes, timing.
// assumes a 100 MHz clock and 6-bit register addresses.
`ifndef CLOCK_CTRL_PARAMS_SVH
`define CLOCK_CTRL_PARAMS_SVH

// ====================
// register map
`define CC_STATUS_ADDR 6'h10
`define CC_SLEEP_ADDR 6'h11
`define CC_T1SEL_ADDR 6'h12
`define CC_PLL_REG_ADDR 6'h29
`define CC_OSC_CAL_ADDR 6'h31

// ====================
// field positions and reset values
`define CC_PLL_LOCK_BIT 0
`define CC_PLL_EN_BIT 1
`define CC_SLEEP_GO_BIT 7
`define CC_T1_FAST_BIT 3
`define CC_OSC_CAL_RESET 8'h80

// ====================
// fuse codes, clock-select field (programmed fuse reads 0)
`define CC_CLOCK_SELECT_FUSES_EXT_CLK 4'h0
`define CC_CLOCK_SELECT_FUSES_RC_HI 4'h4
`define CC_CLOCK_SELECT_FUSES_XRC_HI 4'h8
`define CC_CLOCK_SELECT_FUSES_LF_XTAL 4'h9
`define CC_FACTORY_CLOCK_SELECT_FUSES 4'h1
`define CC_FACTORY_SUT 2'h2
`define CC_FACTORY_PLL_CLOCK_FUSE 1'h1

// ====================
// timing
`define CC_CLK_KHZ 100000
`define CC_PLL_REF_KHZ 1000
`define CC_PLL_MAX_KHZ 70000
`define CC_PLL_MULT 8'h40
`define CC_REF_PERIOD (`CC_CLK_KHZ / `CC_PLL_REF_KHZ)
`define CC_REF_PERIOD_TOL 2
`define CC_LOCK_REFS 8
`define CC_WDT_SHORT_CYCLES 4096
`define CC_WDT_LONG_CYCLES 65536
`define CC_PD_STARTUP_CYCLES 1024

`endif

// ===== rtl/clock_ctrl_pkg.sv
// types shared by the clock control block.
// assumes nothing beyond a SystemVerilog compiler.
package clock_ctrl_pkg;

  // ====================
  // clock sources, sleep modes, sequencer states
  typedef enum logic [2:0] {
    SRC_EXT_CLK, SRC_INT_RC, SRC_EXT_RC, SRC_LF_XTAL, SRC_XTAL, SRC_PLL
  } clk_src_t;

  typedef enum logic [1:0] {
    SLP_IDLE, SLP_ADC_NR, SLP_PDOWN, SLP_STANDBY
  } sleep_mode_t;

  typedef enum logic [2:0] {
    ST_FUSE, ST_RESET_DELAY, ST_STARTUP, ST_RUN, ST_SLEEP
  } cc_state_t;

endpackage : clock_ctrl_pkg

// ===== rtl/pll_ref_tracker.sv
// pll model: reference period, lock and fast cycles per period.
// assumes ref_edge_i is a synchronised one-cycle pulse on clock_i.
`timescale 1ns/10ps
`include "clock_ctrl_params.svh"

module pll_ref_tracker #(
  parameter int LOCK_REFS = `CC_LOCK_REFS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic pll_on_i,
  input wire logic ref_edge_i,
  output logic locked_o,
  output logic saturated_o,
  output logic [7:0] burst_o,
  output logic burst_valid_o
);

  logic [11:0] period_r;
  logic seen_edge_r;
  logic [3:0] lock_cnt_r;
  logic in_range;
  logic [31:0] sat_cycles;

  // reference at or below nominal keeps the loop in range
  assign in_range = period_r >= 12'(`CC_REF_PERIOD - `CC_REF_PERIOD_TOL);
  // capped output: 70 MHz worth of cycles over the measured period
  assign sat_cycles = (32'(period_r) * `CC_PLL_MAX_KHZ) / `CC_CLK_KHZ;

  // ====================
  // period measurement
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      period_r <= 12'h000;
      seen_edge_r <= 1'b0;
    end else if (!pll_on_i) begin
      period_r <= 12'h000;
      seen_edge_r <= 1'b0;
    end else if (ref_edge_i) begin
      period_r <= 12'h001;
      seen_edge_r <= 1'b1;
    end else if (period_r != 12'hfff) begin
      period_r <= period_r + 12'h001;
    end
  end

  // ====================
  // lock tracking and output bursts
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_cnt_r <= 4'h0;
      locked_o <= 1'b0;
      saturated_o <= 1'b0;
      burst_o <= 8'h00;
      burst_valid_o <= 1'b0;
    end else if (!pll_on_i) begin
      lock_cnt_r <= 4'h0;
      locked_o <= 1'b0;
      saturated_o <= 1'b0;
      burst_o <= 8'h00;
      burst_valid_o <= 1'b0;
    end else begin
      burst_valid_o <= ref_edge_i && seen_edge_r;
      if (ref_edge_i && seen_edge_r) begin
        if (in_range) begin
          burst_o <= `CC_PLL_MULT;
          saturated_o <= 1'b0;
          if (32'(lock_cnt_r) >= LOCK_REFS - 1) begin
            locked_o <= 1'b1;
          end else begin
            lock_cnt_r <= lock_cnt_r + 4'h1;
          end
        end else begin
          burst_o <= sat_cycles[7:0];
          saturated_o <= 1'b1;
          locked_o <= 1'b0;
          lock_cnt_r <= 4'h0;
        end
      end
    end
  end

endmodule : pll_ref_tracker

// ===== rtl/clock_system_ctrl.sv
// clock control: source selection from fuses, reset and wake start-up
// timing, sleep-mode clock gating, pll control and timer1 clock feed.
// assumes oscillator pins and wake arrive asynchronously; the register
// port is driven by core logic on clock_i.
//
// Notes on behaviour
// - sleep modes gate off clocks of idle domains.
// - core clock stopped: core performs nothing; register writes are ignored.
// - io clock feeds timers, serial unit, interrupts; async wake still detected.
// - flash clock runs and stops with the core clock.
// - converter clock keeps running in converter noise-reduction sleep.
// - pll multiplies a 1 MHz reference by 64.
// - timer1 counts fast peripheral clock or a prescaled version.
// - calibration changes move the fast clock proportionally.
// - reference above 1 MHz: fast clock caps at 70 MHz, unlocked.
// - pll runs only if enable bit set or pll fuse programmed.
// - lock flag set once pll has locked.
// - rc oscillator and pll off in power-down and standby.
// - pll fuse one: select codes pick crystal, low-freq, external rc, clock.
// - codes 0100..0001 pick internal rc; pll fuse zero picks pll.
// - crystal pins taken from general io per selected source.
// - fuses read one unprogrammed, zero programmed.
// - wake from power-down counts start-up on source, holding execution.
// - reset adds 4096 or 65536 watchdog oscillator cycles delay.
// - delivered fuses: select 0001, start-up 10, pll fuse unprogrammed.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "clock_ctrl_params.svh"

module clock_system_ctrl #(
  parameter int unsigned WDT_SHORT_CYCLES = `CC_WDT_SHORT_CYCLES,
  parameter int unsigned WDT_LONG_CYCLES = `CC_WDT_LONG_CYCLES,
  parameter int unsigned PD_STARTUP_CYCLES = `CC_PD_STARTUP_CYCLES,
  parameter int LOCK_REFS = `CC_LOCK_REFS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // fuses
  input wire logic fuse_valid_i,
  input wire logic [3:0] clock_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic pll_clock_fuse_i,
  // asynchronous oscillator and wake inputs
  input wire logic rc_osc_i,
  input wire logic src_osc_i,
  input wire logic wdt_osc_i,
  input wire logic wake_i,
  // clock gates and oscillator controls
  output logic core_clock_en_o,
  output logic flash_interface_clock_en_o,
  output logic peripheral_io_clock_en_o,
  output logic converter_clock_en_o,
  output logic fast_peripheral_clock_en_o,
  output logic rc_osc_en_o,
  output logic src_osc_en_o,
  output logic [2:0] clk_src_o,
  output logic [7:0] osc_calibration_value_o,
  output logic crystal_input_pin_take_o,
  output logic crystal_output_pin_take_o,
  output logic pll_lock_flag_o,
  output logic [7:0] t1_step_o
);

  // ======================================================================
  // input synchronisers
  localparam int N_ASYNC = 4;
  logic [N_ASYNC-1:0] async_in;
  logic [N_ASYNC-1:0] sync1_r;
  logic [N_ASYNC-1:0] sync2_r;
  logic [N_ASYNC-1:0] prev_r;
  logic [N_ASYNC-1:0] rise;

  assign async_in = {wake_i, wdt_osc_i, src_osc_i, rc_osc_i};

  // oscillators faster than half of clock_i alias; these are slow models
  genvar gi;
  generate
    for (gi = 0; gi < N_ASYNC; gi++) begin : g_sync
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] && !prev_r[gi];
    end
  endgenerate

  logic rc_edge;
  logic src_edge;
  logic wdt_edge;
  logic wake_edge;
  assign rc_edge = rise[0];
  assign src_edge = rise[1];
  assign wdt_edge = rise[2];
  // clock_i free-runs, so wake is caught even while the io clock is gated
  assign wake_edge = rise[3];

  // ======================================================================
  // fuse capture
  logic [3:0] clock_select_fuses_r;
  logic [1:0] sut_r;
  logic pll_clock_fuse_r;
  clock_ctrl_pkg::clk_src_t src_r;
  clock_ctrl_pkg::cc_state_t state_r;

  function automatic clock_ctrl_pkg::clk_src_t decode_src(input logic pll_clock_fuse,
                                                         input logic [3:0] clock_select_fuses);
    clock_ctrl_pkg::clk_src_t s;
    s = clock_ctrl_pkg::SRC_PLL;
    // a programmed fuse reads zero
    if (!pll_clock_fuse) begin
      s = clock_ctrl_pkg::SRC_PLL;
    end else if (clock_select_fuses == `CC_CLOCK_SELECT_FUSES_EXT_CLK) begin
      s = clock_ctrl_pkg::SRC_EXT_CLK;
    end else if (clock_select_fuses <= `CC_CLOCK_SELECT_FUSES_RC_HI) begin
      s = clock_ctrl_pkg::SRC_INT_RC;
    end else if (clock_select_fuses <= `CC_CLOCK_SELECT_FUSES_XRC_HI) begin
      s = clock_ctrl_pkg::SRC_EXT_RC;
    end else if (clock_select_fuses == `CC_CLOCK_SELECT_FUSES_LF_XTAL) begin
      s = clock_ctrl_pkg::SRC_LF_XTAL;
    end else begin
      s = clock_ctrl_pkg::SRC_XTAL;
    end
    return s;
  endfunction : decode_src

  // reset value is the delivered state; real fuses replace it once valid
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_select_fuses_r <= `CC_FACTORY_CLOCK_SELECT_FUSES;
      sut_r <= `CC_FACTORY_SUT;
      pll_clock_fuse_r <= `CC_FACTORY_PLL_CLOCK_FUSE;
      src_r <= clock_ctrl_pkg::SRC_INT_RC;
    end else if (state_r == clock_ctrl_pkg::ST_FUSE && fuse_valid_i) begin
      clock_select_fuses_r <= clock_select_fuses_i;
      sut_r <= startup_time_fuses_i;
      pll_clock_fuse_r <= pll_clock_fuse_i;
      src_r <= decode_src(pll_clock_fuse_i, clock_select_fuses_i);
    end
  end

  // ======================================================================
  // control registers
  logic pll_enable_bit_r;
  logic [7:0] osc_cal_r;
  clock_ctrl_pkg::sleep_mode_t mode_r;
  logic t1_fast_r;
  logic [2:0] t1_ps_r;
  logic wr_ok;
  logic sleep_go;

  // no software runs while the core clock is stopped
  assign wr_ok = wr_i && state_r == clock_ctrl_pkg::ST_RUN;
  assign sleep_go = wr_ok && addr_i == `CC_SLEEP_ADDR && wdata_i[`CC_SLEEP_GO_BIT];

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_enable_bit_r <= 1'b0;
      osc_cal_r <= `CC_OSC_CAL_RESET;
      mode_r <= clock_ctrl_pkg::SLP_IDLE;
      t1_fast_r <= 1'b0;
      t1_ps_r <= 3'h0;
    end else if (wr_ok) begin
      case (addr_i)
        `CC_PLL_REG_ADDR: pll_enable_bit_r <= wdata_i[`CC_PLL_EN_BIT];
        // software must keep the reference at or below 1 MHz
        `CC_OSC_CAL_ADDR: osc_cal_r <= wdata_i;
        `CC_SLEEP_ADDR: mode_r <= clock_ctrl_pkg::sleep_mode_t'(wdata_i[1:0]);
        `CC_T1SEL_ADDR: begin
          t1_fast_r <= wdata_i[`CC_T1_FAST_BIT];
          t1_ps_r <= wdata_i[2:0];
        end
        default: ;
      endcase
    end
  end

  // ======================================================================
  // start-up sequencer
  logic [16:0] cnt_r;
  logic [16:0] wdt_target;
  logic src_tick;
  logic deep_sleep;

  // internal rc and pll sources are timed on the rc reference
  assign src_tick = (src_r == clock_ctrl_pkg::SRC_INT_RC || src_r == clock_ctrl_pkg::SRC_PLL)
                    ? rc_edge : src_edge;
  assign wdt_target = sut_r[1] ? 17'(WDT_LONG_CYCLES) : 17'(WDT_SHORT_CYCLES);
  assign deep_sleep = state_r == clock_ctrl_pkg::ST_SLEEP &&
                      (mode_r == clock_ctrl_pkg::SLP_PDOWN || mode_r == clock_ctrl_pkg::SLP_STANDBY);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= clock_ctrl_pkg::ST_FUSE;
      cnt_r <= 17'h0_0000;
    end else begin
      case (state_r)
        clock_ctrl_pkg::ST_FUSE: begin
          if (fuse_valid_i) begin
            state_r <= clock_ctrl_pkg::ST_RESET_DELAY;
            cnt_r <= 17'h0_0000;
          end
        end
        clock_ctrl_pkg::ST_RESET_DELAY: begin
          if (cnt_r >= wdt_target) begin
            state_r <= clock_ctrl_pkg::ST_STARTUP;
            cnt_r <= 17'h0_0000;
          end else if (wdt_edge) begin
            cnt_r <= cnt_r + 17'h0_0001;
          end
        end
        clock_ctrl_pkg::ST_STARTUP: begin
          if (cnt_r >= 17'(PD_STARTUP_CYCLES)) begin
            state_r <= clock_ctrl_pkg::ST_RUN;
            cnt_r <= 17'h0_0000;
          end else if (src_tick) begin
            cnt_r <= cnt_r + 17'h0_0001;
          end
        end
        clock_ctrl_pkg::ST_RUN: begin
          if (sleep_go) begin
            state_r <= clock_ctrl_pkg::ST_SLEEP;
          end
        end
        clock_ctrl_pkg::ST_SLEEP: begin
          if (wake_edge) begin
            if (deep_sleep) begin
              state_r <= clock_ctrl_pkg::ST_STARTUP;
              cnt_r <= 17'h0_0000;
            end else begin
              state_r <= clock_ctrl_pkg::ST_RUN;
            end
          end
        end
        default: begin
          state_r <= clock_ctrl_pkg::ST_FUSE;
          cnt_r <= 17'h0_0000;
        end
      endcase
    end
  end

  // ======================================================================
  // clock gates and oscillator enables
  logic run;
  logic io_on;
  logic adc_on;
  logic pll_on;
  logic ext_src;
  logic src_on;

  assign run = state_r == clock_ctrl_pkg::ST_RUN;
  assign io_on = run || (state_r == clock_ctrl_pkg::ST_SLEEP &&
                         mode_r == clock_ctrl_pkg::SLP_IDLE);
  assign adc_on = io_on || (state_r == clock_ctrl_pkg::ST_SLEEP &&
                            mode_r == clock_ctrl_pkg::SLP_ADC_NR);
  assign pll_on = (pll_enable_bit_r || !pll_clock_fuse_r) && !deep_sleep;
  assign ext_src = src_r != clock_ctrl_pkg::SRC_INT_RC && src_r != clock_ctrl_pkg::SRC_PLL;
  // standby keeps an external oscillator running; wake from it still counts the full start-up
  assign src_on = ext_src && !(deep_sleep && mode_r == clock_ctrl_pkg::SLP_PDOWN);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_clock_en_o <= 1'b0;
      flash_interface_clock_en_o <= 1'b0;
      peripheral_io_clock_en_o <= 1'b0;
      converter_clock_en_o <= 1'b0;
      fast_peripheral_clock_en_o <= 1'b0;
      rc_osc_en_o <= 1'b1;
      src_osc_en_o <= 1'b0;
    end else begin
      core_clock_en_o <= run;
      flash_interface_clock_en_o <= run;
      peripheral_io_clock_en_o <= io_on;
      converter_clock_en_o <= adc_on;
      fast_peripheral_clock_en_o <= pll_on;
      rc_osc_en_o <= !deep_sleep;
      src_osc_en_o <= src_on;
    end
  end

  // ======================================================================
  // source report and pin ownership
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_src_o <= 3'h0;
      crystal_input_pin_take_o <= 1'b0;
      crystal_output_pin_take_o <= 1'b0;
      osc_calibration_value_o <= `CC_OSC_CAL_RESET;
    end else begin
      clk_src_o <= src_r;
      crystal_input_pin_take_o <= ext_src;
      crystal_output_pin_take_o <= src_r == clock_ctrl_pkg::SRC_LF_XTAL ||
                                   src_r == clock_ctrl_pkg::SRC_XTAL;
      osc_calibration_value_o <= osc_cal_r;
    end
  end

  // ======================================================================
  // pll and timer1 clock feed
  logic pll_locked;
  logic pll_sat;
  logic [7:0] burst;
  logic burst_valid;

  pll_ref_tracker #(
    .LOCK_REFS(LOCK_REFS)
  ) u_pll (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pll_on_i(pll_on),
    .ref_edge_i(rc_edge),
    .locked_o(pll_locked),
    .saturated_o(pll_sat),
    .burst_o(burst),
    .burst_valid_o(burst_valid)
  );

  logic [8:0] acc_r;
  logic [8:0] acc_sum;
  logic [8:0] acc_mask;

  // remainder is carried so prescaling loses no fast cycles
  assign acc_sum = acc_r + (burst_valid ? {1'b0, burst} : 9'h000);
  assign acc_mask = 9'((9'h001 << t1_ps_r) - 9'h001);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r <= 9'h000;
      t1_step_o <= 8'h00;
      pll_lock_flag_o <= 1'b0;
    end else begin
      pll_lock_flag_o <= pll_locked;
      if (!io_on) begin
        t1_step_o <= 8'h00;
      end else if (t1_fast_r && pll_on) begin
        t1_step_o <= 8'(acc_sum >> t1_ps_r);
        acc_r <= acc_sum & acc_mask;
      end else begin
        t1_step_o <= 8'h01;
        acc_r <= 9'h000;
      end
    end
  end

  // ======================================================================
  // read port
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `CC_STATUS_ADDR: rdata_o <= {1'b0, sut_r, pll_sat, pll_on, src_r};
        `CC_SLEEP_ADDR: rdata_o <= {6'h00, mode_r};
        `CC_T1SEL_ADDR: rdata_o <= {4'h0, t1_fast_r, t1_ps_r};
        `CC_PLL_REG_ADDR: rdata_o <= {6'h00, pll_enable_bit_r, pll_locked};
        `CC_OSC_CAL_ADDR: rdata_o <= osc_cal_r;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : clock_system_ctrl

// ===== dv/clock_system_ctrl_properties.sv
// checker for the clock control block.
// assumes it is bound into the top module and sees only its ports.
`timescale 1ns/10ps
`include "clock_ctrl_params.svh"
module clock_system_ctrl_properties (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] addr_i,
  input wire logic wr_i,
  input wire logic core_clock_en_o,
  input wire logic flash_interface_clock_en_o,
  input wire logic peripheral_io_clock_en_o,
  input wire logic converter_clock_en_o,
  input wire logic fast_peripheral_clock_en_o,
  input wire logic rc_osc_en_o,
  input wire logic [2:0] clk_src_o,
  input wire logic [7:0] osc_calibration_value_o,
  input wire logic crystal_input_pin_take_o,
  input wire logic crystal_output_pin_take_o,
  input wire logic pll_lock_flag_o
);
  // ====================
  // properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic internal_src;
  assign internal_src = (clk_src_o == clock_ctrl_pkg::SRC_INT_RC) ||
                        (clk_src_o == clock_ctrl_pkg::SRC_PLL);

  flash_follows_a: assert property (
    flash_interface_clock_en_o == core_clock_en_o) else $error("flash gate differs");
  core_needs_io_a: assert property (
    !peripheral_io_clock_en_o |-> !core_clock_en_o) else $error("core runs without io");
  io_needs_adc_a: assert property (
    !converter_clock_en_o |-> !peripheral_io_clock_en_o) else $error("io runs, adc off");
  rc_off_core_a: assert property (
    !rc_osc_en_o |-> !core_clock_en_o) else $error("core runs with rc off");
  // gates are registered, so allow one cycle of skew
  rc_off_pll_a: assert property (
    !rc_osc_en_o [*2] |-> !fast_peripheral_clock_en_o) else $error("pll on in deep sleep");
  lock_needs_pll_a: assert property (
    $rose(pll_lock_flag_o) |-> fast_peripheral_clock_en_o) else $error("lock without pll");
  output_pin_a: assert property (
    crystal_output_pin_take_o |-> crystal_input_pin_take_o) else $error("output pin alone");
  internal_pins_a: assert property (
    core_clock_en_o && internal_src |-> !crystal_input_pin_take_o && !crystal_output_pin_take_o)
    else $error("pin taken for internal source");
  source_hold_a: assert property (
    $past(core_clock_en_o) |-> $stable(clk_src_o)) else $error("source changed in run");
  sleep_write_a: assert property (
    wr_i && addr_i == `CC_OSC_CAL_ADDR ##1 !core_clock_en_o
    |=> $stable(osc_calibration_value_o)) else $error("write taken in sleep");
endmodule : clock_system_ctrl_properties

// ===== dv/osc_model.sv
// behavioural oscillators on the far side of the clock control block.
// assumes 1 ns units; a disabled oscillator stands low.
`timescale 1ns/10ps
module osc_model #(
  parameter int SRC_HALF_NS = 37,
  parameter int WDT_HALF_NS = 53
) (
  input wire logic rc_en_i,
  input wire logic src_en_i,
  input wire logic [7:0] cal_i,
  output logic rc_osc_o,
  output logic src_osc_o,
  output logic wdt_osc_o
);
  // ====================
  // oscillators
  // reference is 1 MHz at reset calibration, faster above it
  initial begin
    rc_osc_o = 1'b0;
    forever begin
      #((cal_i > 8'h80) ? 400 : 500);
      rc_osc_o = rc_en_i ? ~rc_osc_o : 1'b0;
    end
  end
  initial begin
    src_osc_o = 1'b0;
    forever begin
      #(SRC_HALF_NS);
      src_osc_o = src_en_i ? ~src_osc_o : 1'b0;
    end
  end
  // watchdog oscillator runs free
  initial begin
    wdt_osc_o = 1'b0;
    forever #(WDT_HALF_NS) wdt_osc_o = ~wdt_osc_o;
  end
endmodule : osc_model

// ===== dv/clock_system_ctrl_tb.sv
// self-checking bench for the clock control block.
// assumes the oscillator model beside it and shortened start-up counts.
`timescale 1ns/10ps
`include "clock_ctrl_params.svh"
module clock_system_ctrl_tb;
  localparam int WDT_SHORT = 16;
  localparam int WDT_LONG = 64;
  localparam int PD_START = 8;
  localparam int WDT_NS = 106;
  localparam int SRC_NS = 74;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fuse_valid_i = 1'b0;
  logic [3:0] clock_select_fuses_i = 4'h1;
  logic [1:0] startup_time_fuses_i = 2'h2;
  logic pll_clock_fuse_i = 1'b1;
  logic wake_i = 1'b0;
  logic rc_osc_i, src_osc_i, wdt_osc_i, core_clock_en_o, flash_interface_clock_en_o;
  logic peripheral_io_clock_en_o, converter_clock_en_o, fast_peripheral_clock_en_o;
  logic rc_osc_en_o, src_osc_en_o, crystal_input_pin_take_o, crystal_output_pin_take_o;
  logic pll_lock_flag_o;
  logic [7:0] rdata_o, osc_calibration_value_o, t1_step_o, rd_val;
  logic [2:0] clk_src_o, src_seen;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_cyc, acc, lim;

  clock_system_ctrl #(.WDT_SHORT_CYCLES(WDT_SHORT), .WDT_LONG_CYCLES(WDT_LONG),
    .PD_STARTUP_CYCLES(PD_START), .LOCK_REFS(8)) dut (
    .clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .fuse_valid_i,
    .clock_select_fuses_i, .startup_time_fuses_i, .pll_clock_fuse_i, .rc_osc_i,
    .src_osc_i, .wdt_osc_i, .wake_i, .core_clock_en_o, .flash_interface_clock_en_o,
    .peripheral_io_clock_en_o, .converter_clock_en_o, .fast_peripheral_clock_en_o,
    .rc_osc_en_o, .src_osc_en_o, .clk_src_o, .osc_calibration_value_o,
    .crystal_input_pin_take_o, .crystal_output_pin_take_o, .pll_lock_flag_o, .t1_step_o);

  osc_model #(.SRC_HALF_NS(SRC_NS / 2), .WDT_HALF_NS(WDT_NS / 2)) osc (
    .rc_en_i(rc_osc_en_o), .src_en_i(src_osc_en_o), .cal_i(osc_calibration_value_o),
    .rc_osc_o(rc_osc_i), .src_osc_o(src_osc_i), .wdt_osc_o(wdt_osc_i));

  // ====================
  // tasks
  initial forever #5 clock_i = ~clock_i;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd

  // bounded wait for core gate or lock
  task automatic wait_for(input bit lk);
    n_cyc = 0;
    while ((lk ? pll_lock_flag_o : core_clock_en_o) !== 1'b1 && n_cyc < 20000) begin
      @(posedge clock_i);
      #1 n_cyc++;
    end
  endtask : wait_for

  task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic p);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    clock_select_fuses_i <= c;
    startup_time_fuses_i <= s;
    pll_clock_fuse_i <= p;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    fuse_valid_i <= 1'b1;
    wait_for(0);
  endtask : boot

  // timer1 ticks over a window from a reference edge
  task automatic sum_steps(input int n);
    @(posedge rc_osc_i);
    @(posedge clock_i);
    acc = 0;
    repeat (n) begin
      @(posedge clock_i);
      #1 acc += t1_step_o;
    end
  endtask : sum_steps

  function automatic logic [4:0] exp_fuse(input logic [3:0] c, input logic p);
    logic [2:0] s;
    if (!p) s = clock_ctrl_pkg::SRC_PLL;
    else if (c == 4'h0) s = clock_ctrl_pkg::SRC_EXT_CLK;
    else if (c <= 4'h4) s = clock_ctrl_pkg::SRC_INT_RC;
    else if (c <= 4'h8) s = clock_ctrl_pkg::SRC_EXT_RC;
    else if (c == 4'h9) s = clock_ctrl_pkg::SRC_LF_XTAL;
    else s = clock_ctrl_pkg::SRC_XTAL;
    return {s, s != clock_ctrl_pkg::SRC_INT_RC && s != clock_ctrl_pkg::SRC_PLL,
            s == clock_ctrl_pkg::SRC_LF_XTAL || s == clock_ctrl_pkg::SRC_XTAL};
  endfunction : exp_fuse

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // ====================
  // tests
  initial begin
    // delivered fuses, long then short delay
    for (int i = 1; i >= 0; i--) begin
      boot(4'h1, 2'(i * 2), 1'b1);
      lim = i ? WDT_LONG : WDT_SHORT;
      check("start-up floor", 1, n_cyc * 10 >= lim * WDT_NS);
      check("start-up ceiling", 1, n_cyc * 10 < (lim + 4) * WDT_NS + PD_START * 1000);
      check("delivered source", clock_ctrl_pkg::SRC_INT_RC, clk_src_o);
    end
    $display("test start-up done");
    for (int k = 0; k < 17; k++) begin
      boot(k == 16 ? 4'h1 : 4'(k), 2'h0, k != 16);
      check("source and pins", exp_fuse(4'(k), k != 16),
        {clk_src_o, crystal_input_pin_take_o, crystal_output_pin_take_o});
      check("pll by fuse", k == 16, fast_peripheral_clock_en_o);
      src_seen = clk_src_o;
      clock_select_fuses_i <= ~clock_select_fuses_i;
      pll_clock_fuse_i <= ~pll_clock_fuse_i;
      repeat (3) @(posedge clock_i);
      check("source held", src_seen, clk_src_o);
    end
    $display("test fuse table done");
    boot(4'h1, 2'h0, 1'b1);
    rd(6'h3F);
    check("unmapped read", 8'h00, rd_val);
    rd(`CC_OSC_CAL_ADDR);
    check("calibration reset", `CC_OSC_CAL_RESET, rd_val);
    wr(`CC_PLL_REG_ADDR, 8'h02);
    wait_for(1);
    check("lock flag", 1, pll_lock_flag_o);
    rd(`CC_PLL_REG_ADDR);
    check("pll register", 8'h03, rd_val);
    for (int i = 0; i < 3; i++) begin
      wr(`CC_T1SEL_ADDR, i == 2 ? 8'h00 : 8'h08 | 8'(i * 2));
      sum_steps(1000);
      check("timer1 ticks", i == 2 ? 1000 : 640 >> (i * 2), acc);
    end
    wr(`CC_OSC_CAL_ADDR, 8'hA0);
    wr(`CC_T1SEL_ADDR, 8'h08);
    repeat (400) @(posedge clock_i);
    check("lock lost", 0, pll_lock_flag_o);
    rd(`CC_STATUS_ADDR);
    check("saturated", 1, rd_val[4]);
    sum_steps(800);
    check("capped ticks", 560, acc);
    wr(`CC_OSC_CAL_ADDR, 8'h80);
    $display("test pll done");
    for (int m = 0; m < 4; m++) begin
      wr(`CC_SLEEP_ADDR, 8'h80 | 8'(m));
      repeat (3) @(posedge clock_i);
      #1 check("gates", m == 0 ? 6'h0F : m == 1 ? 6'h07 : 6'h00,
        {core_clock_en_o, flash_interface_clock_en_o, peripheral_io_clock_en_o,
         converter_clock_en_o, rc_osc_en_o, fast_peripheral_clock_en_o});
      wr(`CC_OSC_CAL_ADDR, 8'h11);
      @(posedge clock_i);
      wake_i <= 1'b1;
      wait_for(0);
      @(posedge clock_i);
      wake_i <= 1'b0;
      check("wake span", m >= 2, n_cyc >= PD_START * SRC_NS / 10);
      check("awake", 1, core_clock_en_o);
      rd(`CC_OSC_CAL_ADDR);
      check("sleep write", 8'h80, rd_val);
    end
    $display("test sleep done");
    complete_run();
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("mismatch cycles expected <40000 seen %0d", cycles);
      complete_run();
    end
  end
endmodule : clock_system_ctrl_tb

bind clock_system_ctrl clock_system_ctrl_properties chk (
  .clock_i, .sys_rst_i, .addr_i, .wr_i, .core_clock_en_o, .flash_interface_clock_en_o,
  .peripheral_io_clock_en_o, .converter_clock_en_o, .fast_peripheral_clock_en_o,
  .rc_osc_en_o, .clk_src_o, .osc_calibration_value_o, .crystal_input_pin_take_o,
  .crystal_output_pin_take_o, .pll_lock_flag_o);
